// File: hdl/host_interrupt_mask_gate.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module host_interrupt_mask_gate (
  input wire logic clk,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] eventFlags,
  input wire logic timedReceiveAny,
  input wire logic timedTransmitAny,
  output logic cpuIrq,
  output logic noteIrq
);

  function automatic host_irq_pkg::regsel_t decodeAdr(input logic [7:0] a);
    host_irq_pkg::regsel_t s;
    s = host_irq_pkg::SEL_NONE;
    if (a == host_irq_pkg::MASK_SET_OFS) begin
      s = host_irq_pkg::SEL_MASK_SET;
    end else if (a == host_irq_pkg::MASK_CLR_OFS) begin
      s = host_irq_pkg::SEL_MASK_CLR;
    end else if (a == host_irq_pkg::NOTE_STAT_OFS) begin
      s = host_irq_pkg::SEL_NOTE_STAT;
    end else if (a == host_irq_pkg::NOTE_MASK_OFS) begin
      s = host_irq_pkg::SEL_NOTE_MASK;
    end else if (a == host_irq_pkg::MASKED_VIEW_OFS) begin
      s = host_irq_pkg::SEL_VIEW;
    end
    return s;
  endfunction

  function automatic logic [31:0] laneBits(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] noteMask_r;
  logic [1:0] noteMask_nxt;
  logic cpuIrq_r;
  logic cpuIrq_nxt;
  logic noteIrq_r;
  logic noteIrq_nxt;
  logic [31:0] evVec;
  logic [31:0] maskedView;
  logic [31:0] wrBits;
  logic req;
  logic fire;
  host_irq_pkg::regsel_t selReg;

  always_comb begin
    // event vector with the live timed levels merged in
    evVec = eventFlags & host_irq_pkg::EVENT_USED;
    evVec[host_irq_pkg::TIMED_RX_BIT] = timedReceiveAny;
    evVec[host_irq_pkg::TIMED_TX_BIT] = timedTransmitAny;
    maskedView = evVec & mask_r;
    maskedView[host_irq_pkg::GATE_BIT] = 1'b0;
    req = cyc_i & stb_i;
    fire = req & ack_r;
    selReg = decodeAdr(adr_i);
    wrBits = dat_i & laneBits(sel_i) & host_irq_pkg::MASK_WRITABLE;
    ack_nxt = req & ~ack_r;
    dat_nxt = dat_r;
    if (req && !ack_r) begin
      unique case (selReg)
        host_irq_pkg::SEL_MASK_SET: dat_nxt = mask_r;
        host_irq_pkg::SEL_MASK_CLR: dat_nxt = mask_r;
        host_irq_pkg::SEL_NOTE_STAT: dat_nxt = {30'h0000_0000, stat_r};
        host_irq_pkg::SEL_NOTE_MASK: dat_nxt = {30'h0000_0000, noteMask_r};
        host_irq_pkg::SEL_VIEW: dat_nxt = maskedView;
        host_irq_pkg::SEL_NONE: dat_nxt = host_irq_pkg::DATA_RESET;
      endcase
    end
    mask_nxt = mask_r;
    noteMask_nxt = noteMask_r;
    stat_nxt = stat_r;
    if (fire && we_i) begin
      unique case (selReg)
        host_irq_pkg::SEL_MASK_SET: mask_nxt = mask_r | wrBits;
        host_irq_pkg::SEL_MASK_CLR: mask_nxt = mask_r & ~wrBits;
        host_irq_pkg::SEL_NOTE_MASK: noteMask_nxt = dat_i[1:0] & {2{sel_i[0]}};
        host_irq_pkg::SEL_NOTE_STAT,
        host_irq_pkg::SEL_VIEW,
        host_irq_pkg::SEL_NONE: mask_nxt = mask_r;
      endcase
    end
    if (fire && !we_i && selReg == host_irq_pkg::SEL_NOTE_STAT) begin
      stat_nxt = host_irq_pkg::NOTE_CLEAR;
    end
    // gate, then per-source enable
    cpuIrq_nxt = mask_r[host_irq_pkg::GATE_BIT] & (|maskedView[30:0]);
    // set wins over the read clear
    if (cpuIrq_nxt && !cpuIrq_r) begin
      stat_nxt[host_irq_pkg::NOTE_ROSE_BIT] = 1'b1;
    end
    if (fire && selReg == host_irq_pkg::SEL_NONE) begin
      stat_nxt[host_irq_pkg::NOTE_UNMAPPED_BIT] = 1'b1;
    end
    noteIrq_nxt = |(stat_nxt & noteMask_nxt);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_r <= host_irq_pkg::DATA_RESET;
      mask_r <= host_irq_pkg::MASK_RESET;
      stat_r <= host_irq_pkg::NOTE_RESET;
      noteMask_r <= host_irq_pkg::NOTE_RESET;
      cpuIrq_r <= 1'b0;
      noteIrq_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      noteMask_r <= noteMask_nxt;
      cpuIrq_r <= cpuIrq_nxt;
      noteIrq_r <= noteIrq_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign cpuIrq = cpuIrq_r;
  assign noteIrq = noteIrq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_set_write: assert property (
    fire && we_i && selReg == host_irq_pkg::SEL_MASK_SET && wrBits != 32'h0
    |=> (mask_r & $past(wrBits)) == $past(wrBits))
    else $error("set write did not set mask bits");

  a_set_keeps: assert property (
    fire && we_i && selReg == host_irq_pkg::SEL_MASK_SET
    |=> (mask_r & ~$past(wrBits)) == ($past(mask_r) & ~$past(wrBits)))
    else $error("set write disturbed other bits");

  a_clr_write: assert property (
    fire && we_i && selReg == host_irq_pkg::SEL_MASK_CLR
    |=> (mask_r & $past(wrBits)) == 32'h0000_0000)
    else $error("clear write left mask bits set");

  a_read_mask: assert property (
    req && !ack_r && !we_i
    && (selReg == host_irq_pkg::SEL_MASK_SET || selReg == host_irq_pkg::SEL_MASK_CLR)
    |=> ack_o && dat_o == $past(mask_r))
    else $error("mask read returned wrong data");

  a_read_stable: assert property (
    fire && !we_i
    && (selReg == host_irq_pkg::SEL_MASK_SET || selReg == host_irq_pkg::SEL_MASK_CLR)
    |=> $stable(mask_r))
    else $error("mask read changed the mask");

  a_rsvd_28: assert property (!mask_r[28] && !(ack_o && dat_o[28]))
    else $error("reserved bit 28 set");

  a_rsvd_14_10: assert property (
    ##1 ack_o && $past(selReg == host_irq_pkg::SEL_MASK_SET) |-> dat_o[14:10] == 5'h00)
    else $error("reserved bits 14..10 read nonzero");

  a_gate_blocks: assert property (
    !mask_r[host_irq_pkg::GATE_BIT] |=> !cpuIrq)
    else $error("interrupt with gate clear");

  a_irq_follows: assert property (
    mask_r[host_irq_pkg::GATE_BIT] && (|(evVec[30:0] & mask_r[30:0])) |=> cpuIrq)
    else $error("enabled event gave no interrupt");

  a_no_cause: assert property (
    !(|(evVec[30:0] & mask_r[30:0])) |=> !cpuIrq)
    else $error("interrupt without enabled event");

  a_maker_src: assert property (
    mask_r[31] && mask_r[30] && eventFlags[30] |=> cpuIrq)
    else $error("maker defined event blocked");

  a_soft_src: assert property (
    mask_r[31] && mask_r[29] && eventFlags[29] |=> cpuIrq)
    else $error("software event blocked");

  a_mid_src: assert property (
    mask_r[31] && mask_r[17] && eventFlags[17] |=> cpuIrq)
    else $error("bus init event blocked");

  a_low_src: assert property (
    mask_r[31] && mask_r[0] && eventFlags[0] |=> cpuIrq)
    else $error("request send event blocked");

  a_timed_level: assert property (
    mask_r[31] && mask_r[7] && !mask_r[6] && (mask_r[30:8] & evVec[30:8]) == 23'h0
    && (mask_r[5:0] & evVec[5:0]) == 6'h00 && !timedReceiveAny |=> !cpuIrq)
    else $error("timed receive level latched");

  a_align: assert property (evVec[27:15] == eventFlags[27:15])
    else $error("event vector misaligned");

  a_view_gate: assert property (
    req && !ack_r && selReg == host_irq_pkg::SEL_VIEW
    |=> dat_o[30:0] == $past(evVec[30:0] & mask_r[30:0]))
    else $error("masked view depends on gate");

  a_note_sticky: assert property (
    cpuIrq_nxt && !cpuIrq_r |=> stat_r[host_irq_pkg::NOTE_ROSE_BIT])
    else $error("rise note lost");

  a_ack_answer: assert property (req && !ack_r |=> ack_o)
    else $error("request left without ack");

  a_ack_cause: assert property (ack_o |-> $past(req))
    else $error("ack without a request");

  a_clr_keeps: assert property (
    fire && we_i && selReg == host_irq_pkg::SEL_MASK_CLR
    |=> (mask_r & ~$past(wrBits)) == ($past(mask_r) & ~$past(wrBits)))
    else $error("clear write disturbed other bits");

  a_mask_idle: assert property (
    !(fire && we_i && (selReg == host_irq_pkg::SEL_MASK_SET
    || selReg == host_irq_pkg::SEL_MASK_CLR)) |=> $stable(mask_r))
    else $error("mask changed without a mask write");

  a_rsvd_mask: assert property (
    (mask_r & ~host_irq_pkg::MASK_WRITABLE) == 32'h0000_0000)
    else $error("reserved mask bit held one");

  a_view_rsvd: assert property (
    ack_o && $past(!we_i && selReg == host_irq_pkg::SEL_VIEW)
    |-> !dat_o[31] && !dat_o[28] && dat_o[14:10] == 5'h00)
    else $error("masked view showed an unused bit");

  a_view_align: assert property (
    req && !ack_r && selReg == host_irq_pkg::SEL_VIEW
    |=> dat_o[27:15] == $past(eventFlags[27:15] & mask_r[27:15]))
    else $error("masked view misaligned");

  a_rx_follows: assert property (
    mask_r[31] && mask_r[7] && timedReceiveAny |=> cpuIrq)
    else $error("timed receive level blocked");

  a_tx_follows: assert property (
    mask_r[31] && mask_r[6] && timedTransmitAny |=> cpuIrq)
    else $error("timed transmit level blocked");

  a_tx_level: assert property (
    mask_r[31] && mask_r[6] && !mask_r[7] && (mask_r[30:8] & evVec[30:8]) == 23'h0
    && (mask_r[5:0] & evVec[5:0]) == 6'h00 && !timedTransmitAny |=> !cpuIrq)
    else $error("timed transmit level latched");

  a_unmapped_zero: assert property (
    req && !ack_r && selReg == host_irq_pkg::SEL_NONE |=> dat_o == host_irq_pkg::DATA_RESET)
    else $error("unmapped read returned data");

  a_unmapped_note: assert property (
    fire && selReg == host_irq_pkg::SEL_NONE |=> stat_r[host_irq_pkg::NOTE_UNMAPPED_BIT])
    else $error("unmapped access note lost");

  a_note_clear: assert property (
    fire && !we_i && selReg == host_irq_pkg::SEL_NOTE_STAT && !(cpuIrq_nxt && !cpuIrq_r)
    |=> stat_r == host_irq_pkg::NOTE_CLEAR)
    else $error("status read did not clear");

  a_note_mask_wr: assert property (
    fire && we_i && selReg == host_irq_pkg::SEL_NOTE_MASK && sel_i[0]
    |=> noteMask_r == $past(dat_i[1:0]))
    else $error("note mask write lost");

  a_note_irq: assert property (noteIrq == (|(stat_r & noteMask_r)))
    else $error("note interrupt out of step");

  a_dat_hold: assert property (!(req && !ack_r) |=> $stable(dat_o))
    else $error("read data moved without a request");

  c_set_gate: cover property (
    fire && we_i && selReg == host_irq_pkg::SEL_MASK_SET && dat_i[31]);
  c_irq_rise: cover property (!cpuIrq ##1 cpuIrq);
  c_clr_gate: cover property (cpuIrq ##1 !mask_r[31] ##1 !cpuIrq);
  c_view_read: cover property (fire && !we_i && selReg == host_irq_pkg::SEL_VIEW);
  c_note_irq: cover property (!noteIrq ##1 noteIrq);

endmodule
`default_nettype wire

// File: hdl/host_irq_pkg.sv
package host_irq_pkg;
  localparam logic [7:0] MASK_SET_OFS = 8'h88;
  localparam logic [7:0] MASK_CLR_OFS = 8'h8c;
  localparam logic [7:0] NOTE_STAT_OFS = 8'hc0;
  localparam logic [7:0] NOTE_MASK_OFS = 8'hc4;
  localparam logic [7:0] MASKED_VIEW_OFS = 8'hc8;
  localparam int GATE_BIT = 31;
  localparam int TIMED_RX_BIT = 7;
  localparam int TIMED_TX_BIT = 6;
  localparam logic [31:0] MASK_WRITABLE = 32'hefff_83ff;
  localparam logic [31:0] EVENT_USED = 32'h6fff_83ff;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int NOTE_W = 2;
  localparam int NOTE_ROSE_BIT = 0;
  localparam int NOTE_UNMAPPED_BIT = 1;
  localparam logic [1:0] NOTE_RESET = 2'h0;
  localparam logic [1:0] NOTE_CLEAR = 2'h0;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  typedef enum {
    SEL_MASK_SET,
    SEL_MASK_CLR,
    SEL_NOTE_STAT,
    SEL_NOTE_MASK,
    SEL_VIEW,
    SEL_NONE
  } regsel_t;
endpackage

// File: bench/host_interrupt_mask_gate_tb.sv
`timescale 1ns/1ns
`default_nettype none
module host_interrupt_mask_gate_tb;
  logic clk, srst, cyc, stb, we, ack, cpuIrq, noteIrq, rxAny, txAny;
  logic [7:0] adr;
  logic [3:0] sel, lanes;
  logic [31:0] wdat, rdat, ev, m, r, v;
  int n_errors, n_tests, b;
  logic [31:0] notes[$];
  host_interrupt_mask_gate host_interrupt_mask_gate_inst (.clk(clk), .srst(srst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .ack_o(ack), .dat_o(rdat),
    .eventFlags(ev), .timedReceiveAny(rxAny), .timedTransmitAny(txAny), .cpuIrq(cpuIrq),
    .noteIrq(noteIrq));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bad(input string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  // read checker: oldest note against each read answer
  always @(posedge clk) begin
    if (ack && !we) begin
      n_tests++;
      if (notes.size() == 0) bad("read with no note");
      else if (rdat !== notes.pop_front()) bad("read data");
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lanes;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (!ack && i < 20);
    if (!ack) begin
      bad("no ack");
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic irq(input logic e, input logic note);
    repeat (3) @(posedge clk);
    n_tests++;
    if ((note ? noteIrq : cpuIrq) !== e) bad("interrupt level");
  endtask
  initial begin
    cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
    lanes = 4'hf;
    ev = 0; rxAny = 0; txAny = 0; srst = 1; n_errors = 0; n_tests = 0;
    void'($urandom(77186));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'h88, host_irq_pkg::MASK_RESET);
    wb(1'b1, 8'h88, 32'hffff_ffff);
    rd(8'h88, host_irq_pkg::MASK_WRITABLE);
    rd(8'h8c, host_irq_pkg::MASK_WRITABLE);
    r = $urandom();
    wb(1'b1, 8'h8c, r);
    wb(1'b1, 8'h88, 32'h0);
    m = host_irq_pkg::MASK_WRITABLE & ~r;
    rd(8'h8c, m);
    rd(8'h88, m);
    $display("register test done");
    ev <= $urandom();
    rxAny <= 1'b1;
    wb(1'b1, 8'h88, 32'h8000_0000);
    v = {ev[31:8], 1'b1, 1'b0, ev[5:0]} & host_irq_pkg::EVENT_USED & m;
    rd(8'hc8, v);
    wb(1'b1, 8'h8c, 32'h8000_0000);
    rd(8'hc8, v);
    $display("masked view test done");
    ev <= 32'h0;
    rxAny <= 1'b0;
    wb(1'b1, 8'h8c, 32'hffff_ffff);
    for (b = 0; b < 31; b++) begin
      if (host_irq_pkg::EVENT_USED[b]) begin
        if (b == 7) rxAny <= 1'b1;
        else if (b == 6) txAny <= 1'b1;
        else ev <= 32'h1 << b;
        wb(1'b1, 8'h88, 32'h8000_0000 | (32'h1 << b));
        irq(1'b1, 1'b0);
        wb(1'b1, 8'h8c, 32'h8000_0000);
        irq(1'b0, 1'b0);
        wb(1'b1, 8'h88, 32'h8000_0000);
        wb(1'b1, 8'h8c, 32'h1 << b);
        irq(1'b0, 1'b0);
        ev <= ~(32'h1 << b);
        rxAny <= (b != 7);
        txAny <= (b != 6);
        wb(1'b1, 8'h88, 32'h1 << b);
        irq(1'b0, 1'b0);
        ev <= 32'h0;
        rxAny <= 1'b0;
        txAny <= 1'b0;
        wb(1'b1, 8'h8c, 32'hffff_ffff);
      end
    end
    $display("interrupt test done");
    rd(8'hc0, 32'h1);
    wb(1'b1, 8'hc4, 32'h2);
    rd(8'h10, 32'h0);
    irq(1'b1, 1'b1);
    rd(8'hc0, 32'h2);
    irq(1'b0, 1'b1);
    $display("note test done");
    wb(1'b1, 8'h8c, 32'hffff_ffff);
    lanes = 4'h2;
    wb(1'b1, 8'h88, 32'hffff_ffff);
    lanes = 4'hf;
    rd(8'h8c, host_irq_pkg::MASK_WRITABLE & 32'h0000_ff00);
    $display("byte lane test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
